// >>> rtl/lbcs_device.sv
// Device end: boost switching, soft-start, control input sequencing
`timescale 1ns/1ps
// Functional notes
// - Switch on when feedback below reference
// - Switch off at active peak limit
// - Force off after maximum on-time
// - Minimum off-time then low feedback
// - Quarter, half, then full limit steps
// - Soft-start done after 512 cycles
// - Enable after 50 us continuous high
// - Each enable restarts soft-start
// - Low 32 ms shuts down, opens LED
// - Shutdown may occur after 10 ms
// - Enabled: LED switch follows high input
// - Blank comparator 400 ns after LED close on a control rise while enabled
// - Host PWM 100 Hz to 50 kHz (lbcs_host does not limit pwm_period)
// - Host high pulse width limits
// - Overvoltage holds main switch off
// - Supply lockout keeps both switches open
// - Over-temperature keeps both switches open
module lbcs_device
    import lbcs_pkg::*;
#(
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC,
    parameter int ENABLE_CYCLES   = ENABLE_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    lbcs_link_if.device       link,
    input  wire logic         fb_below_ref,
    input  wire logic         ilim_quarter_hit,
    input  wire logic         ilim_half_hit,
    input  wire logic         ilim_full_hit,
    input  wire logic         ovp_active,
    input  wire logic         supply_lockout,
    input  wire logic         over_temp,
    output logic              boost_power_switch,
    output logic              led_return_switch,
    output logic              enabled,
    output logic              softstart_done,
    output lbcs_pkg::lbcs_limit_t peak_current_limit
);
    import lbcs_pkg::*;

    typedef enum logic [1:0] {
        LBCS_SW_OFF_WAIT,
        LBCS_SW_READY,
        LBCS_SW_ON
    } lbcs_sw_state_t;

    lbcs_sw_state_t sw_state_r;
    logic           enabled_r;
    logic           ctrl_d_r;
    logic           led_r;
    logic [SS_W-1:0] ss_cnt_r;
    logic           fault;
    logic           high_done;
    logic           low_done;
    logic           on_done;
    logic           off_done;
    logic           blank_done;
    logic           limit_hit;
    logic           ctrl_rise;
    logic           sw_on;
    logic           turn_off;

    assign fault     = supply_lockout || over_temp;
    assign ctrl_rise = link.ctrl_in && !ctrl_d_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_d_r <= 1'b0;
        end else begin
            ctrl_d_r <= link.ctrl_in;
        end
    end

    // High-time qualifier for enable
    lbcs_timer #(.W(TIMER_W)) u_high (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (!link.ctrl_in || fault),
        .run     (!enabled_r),
        .limit   (TIMER_W'(ENABLE_CYCLES)),
        .done    (high_done)
    );

    // Low-time measurement for shutdown
    lbcs_timer #(.W(TIMER_W)) u_low (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (link.ctrl_in),
        .run     (enabled_r),
        .limit   (TIMER_W'(SHUTDOWN_CYCLES)),
        .done    (low_done)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enabled_r <= 1'b0;
        end else if (fault) begin
            enabled_r <= 1'b0;
        end else if (!enabled_r && high_done) begin
            enabled_r <= 1'b1;
        end else if (enabled_r && low_done) begin
            enabled_r <= 1'b0;
        end
    end

    // LED return switch follows control input while enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            led_r <= 1'b0;
        end else if (fault || !enabled_r) begin
            led_r <= 1'b0;
        end else begin
            led_r <= link.ctrl_in;
        end
    end

    // Comparator blanking after LED switch closes on a control rise while enabled
    lbcs_timer #(.W(TIMER_W)) u_blank (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (enabled_r && !fault && ctrl_rise),
        .run     (1'b1),
        .limit   (TIMER_W'(BLANK_CYC)),
        .done    (blank_done)
    );

    // Soft-start switch-cycle counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ss_cnt_r <= '0;
        end else if (!enabled_r) begin
            ss_cnt_r <= '0;
        end else if (turn_off && ss_cnt_r < SS_W'(SS_DONE_CYCLES)) begin
            ss_cnt_r <= ss_cnt_r + 1'b1;
        end
    end

    always_comb begin
        if (ss_cnt_r < SS_W'(SS_STEP_CYCLES)) begin
            peak_current_limit = LBCS_LIM_QUARTER;
        end else if (ss_cnt_r < SS_W'(SS_DONE_CYCLES)) begin
            peak_current_limit = LBCS_LIM_HALF;
        end else begin
            peak_current_limit = LBCS_LIM_FULL;
        end
    end

    always_comb begin
        case (peak_current_limit)
            LBCS_LIM_QUARTER: limit_hit = ilim_quarter_hit;
            LBCS_LIM_HALF:    limit_hit = ilim_half_hit;
            default:          limit_hit = ilim_full_hit;
        endcase
    end

    assign sw_on = (sw_state_r == LBCS_SW_ON);

    // Maximum on-time
    lbcs_timer #(.W(TIMER_W)) u_on (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (!sw_on),
        .run     (1'b1),
        .limit   (TIMER_W'(MAX_ON_CYC - 1)),
        .done    (on_done)
    );

    // Minimum off-time
    lbcs_timer #(.W(TIMER_W)) u_off (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clear   (sw_on),
        .run     (1'b1),
        .limit   (TIMER_W'(MIN_OFF_CYC - 1)),
        .done    (off_done)
    );

    assign turn_off = sw_on && (limit_hit || on_done || ovp_active || fault || !enabled_r);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sw_state_r <= LBCS_SW_OFF_WAIT;
        end else begin
            case (sw_state_r)
                LBCS_SW_OFF_WAIT: begin
                    if (off_done) begin
                        sw_state_r <= LBCS_SW_READY;
                    end
                end
                LBCS_SW_READY: begin
                    if (enabled_r && !fault && !ovp_active && blank_done && fb_below_ref) begin
                        sw_state_r <= LBCS_SW_ON;
                    end
                end
                LBCS_SW_ON: begin
                    if (turn_off) begin
                        sw_state_r <= LBCS_SW_OFF_WAIT;
                    end
                end
                default: sw_state_r <= LBCS_SW_OFF_WAIT;
            endcase
        end
    end

    assign boost_power_switch = sw_on;
    assign led_return_switch  = led_r;
    assign enabled            = enabled_r;
    assign softstart_done     = (peak_current_limit == LBCS_LIM_FULL);
endmodule

// >>> rtl/lbcs_host.sv
// Host end: drives control input as enable and brightness PWM
`timescale 1ns/1ps
module lbcs_host
    import lbcs_pkg::*;
#(
    parameter int PERIOD_W        = 24,
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC,
    parameter int ENABLE_CYCLES   = ENABLE_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    lbcs_link_if.host                link,
    input  wire logic                run_req,
    input  wire logic                pwm_mode,
    input  wire logic                softstart_done,
    input  wire logic [PERIOD_W-1:0] pwm_period,
    input  wire logic [PERIOD_W-1:0] pwm_high_width,
    output logic                     host_enabled
);
    import lbcs_pkg::*;

    typedef enum logic [1:0] {
        LBCS_H_OFF,
        LBCS_H_ENABLE,
        LBCS_H_RUN,
        LBCS_H_SHUTDOWN
    } lbcs_host_state_t;

    lbcs_host_state_t st_r;
    logic [PERIOD_W-1:0] cnt_r;
    logic [PERIOD_W-1:0] phase_r;
    logic [PERIOD_W-1:0] min_high;
    logic [PERIOD_W-1:0] high_w;
    logic                ctrl_r;

    // Host keeps pulses above the width the current phase needs
    assign min_high = softstart_done ? PERIOD_W'(HOST_HIGH_RUN_CYC) : PERIOD_W'(HOST_HIGH_SS_CYC);
    assign high_w   = (pwm_high_width < min_high) ? min_high : pwm_high_width;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r  <= LBCS_H_OFF;
            cnt_r <= '0;
        end else begin
            case (st_r)
                LBCS_H_OFF: begin
                    cnt_r <= '0;
                    if (run_req) begin
                        st_r <= LBCS_H_ENABLE;
                    end
                end
                LBCS_H_ENABLE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= PERIOD_W'(ENABLE_CYCLES)) begin
                        st_r <= LBCS_H_RUN;
                    end
                end
                LBCS_H_RUN: begin
                    cnt_r <= '0;
                    if (!run_req) begin
                        st_r <= LBCS_H_SHUTDOWN;
                    end
                end
                LBCS_H_SHUTDOWN: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r >= PERIOD_W'(SHUTDOWN_CYCLES)) begin
                        st_r <= LBCS_H_OFF;
                    end
                end
                default: st_r <= LBCS_H_OFF;
            endcase
        end
    end

    // PWM phase counter, period set by user; pwm_period is not checked against a band
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_r <= '0;
        end else if (st_r != LBCS_H_RUN || phase_r + 1'b1 >= pwm_period) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 1'b0;
        end else begin
            case (st_r)
                LBCS_H_ENABLE: ctrl_r <= 1'b1;
                LBCS_H_RUN:    ctrl_r <= pwm_mode ? (phase_r < high_w) : 1'b1;
                default:       ctrl_r <= 1'b0;
            endcase
        end
    end

    assign link.ctrl_in = ctrl_r;
    assign host_enabled = (st_r == LBCS_H_RUN);
endmodule

// >>> rtl/lbcs_link_if.sv
// Control input link between host and LED boost sequencer
`timescale 1ns/1ps
interface lbcs_link_if;
    logic ctrl_in;
    modport device (input ctrl_in);
    modport host   (output ctrl_in);
endinterface

// >>> rtl/lbcs_pkg.sv
// Shared constants for the LED boost control sequencer
package lbcs_pkg;
    localparam int CLK_HZ           = 50_000_000;
    localparam int CLK_NS           = 1_000_000_000 / CLK_HZ;
    localparam int MIN_OFF_NS       = 400;
    localparam int BLANK_NS         = 400;
    localparam int MAX_ON_NS        = 6000;
    localparam int ENABLE_US        = 50;
    localparam int SHUTDOWN_MS      = 32;
    localparam int SHUTDOWN_MIN_MS  = 10;
    localparam int HOST_HIGH_SS_NS  = 2500;
    localparam int HOST_HIGH_RUN_NS = 400;
    // Least times round up; host high widths take one cycle past the floor
    localparam int MIN_OFF_CYC      = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_CYC        = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int ENABLE_CYC       = (ENABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HOST_HIGH_SS_CYC = HOST_HIGH_SS_NS / CLK_NS + 1;
    localparam int HOST_HIGH_RUN_CYC = HOST_HIGH_RUN_NS / CLK_NS + 1;
    // Longest time rounds down
    localparam int MAX_ON_CYC       = MAX_ON_NS / CLK_NS;
    localparam int SHUTDOWN_CYC     = SHUTDOWN_MS * (1_000_000 / CLK_NS);
    localparam int SS_STEP_CYCLES   = 256;
    localparam int SS_DONE_CYCLES   = 512;
    localparam int TIMER_W          = 24;
    localparam int SS_W             = 10;
    typedef enum logic [1:0] {
        LBCS_LIM_QUARTER,
        LBCS_LIM_HALF,
        LBCS_LIM_FULL
    } lbcs_limit_t;
endpackage

// >>> rtl/lbcs_timer.sv
// Saturating cycle counter with restart and done flag
`timescale 1ns/1ps
module lbcs_timer #(
    parameter int W = 24
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (clear) begin
            cnt_r <= '0;
        end else if (run && cnt_r < limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign done = !clear && (cnt_r >= limit);
endmodule

// >>> tb/lbcs_chk.sv
// Concurrent checks on the sequencer link and switch outputs
`timescale 1ns/1ps
module lbcs_chk
    import lbcs_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  ctrl_in,
    input wire logic                  ilim_quarter_hit,
    input wire logic                  ilim_half_hit,
    input wire logic                  ilim_full_hit,
    input wire logic                  ovp_active,
    input wire logic                  supply_lockout,
    input wire logic                  over_temp,
    input wire logic                  boost_power_switch,
    input wire logic                  led_return_switch,
    input wire logic                  enabled,
    input wire logic                  softstart_done,
    input wire lbcs_pkg::lbcs_limit_t peak_current_limit
);
    logic [9:0]  on_r;
    logic [9:0]  off_r;
    logic [9:0]  ss_r;
    logic        hit;
    lbcs_limit_t exp_lim;
    assign hit = (peak_current_limit == LBCS_LIM_QUARTER && ilim_quarter_hit)
        || (peak_current_limit == LBCS_LIM_HALF && ilim_half_hit)
        || (peak_current_limit == LBCS_LIM_FULL && ilim_full_hit);
    assign exp_lim = ss_r < 10'h100 ? LBCS_LIM_QUARTER : (ss_r < 10'h200 ? LBCS_LIM_HALF : LBCS_LIM_FULL);
    // Run lengths and turn-off count since enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_r <= 10'h0;
            off_r <= 10'h0;
            ss_r <= 10'h0;
        end else begin
            on_r <= boost_power_switch ? on_r + 10'h1 : 10'h0;
            off_r <= boost_power_switch ? 10'h0 : off_r + {9'h0, off_r != 10'h3ff};
            ss_r <= !enabled ? 10'h0 : ss_r + {9'h0, $fell(boost_power_switch) && ss_r != 10'h3ff};
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_at_limit;
        boost_power_switch && hit;
    endsequence
    chk_limit_turns_off: assert property (s_at_limit |=> !boost_power_switch)
        else $error("switch stayed on at the limit");
    chk_max_on_time: assert property (boost_power_switch |-> on_r < MAX_ON_CYC)
        else $error("switch on too long");
    chk_min_off_time: assert property ($rose(boost_power_switch) |-> off_r >= MIN_OFF_CYC)
        else $error("off time too short");
    chk_softstart_step: assert property (enabled && $past(enabled) && !$fell(boost_power_switch) |->
        peak_current_limit == exp_lim && softstart_done == (exp_lim == LBCS_LIM_FULL))
        else $error("limit step wrong");
    chk_led_follows: assert property (enabled && !supply_lockout && !over_temp |=>
        !enabled || led_return_switch == $past(ctrl_in))
        else $error("led switch not following input");
    chk_led_opens_low: assert property (!ctrl_in |=> !led_return_switch)
        else $error("led switch closed while input low");
    chk_ovp_holds_off: assert property (ovp_active |=> !boost_power_switch)
        else $error("switch on in overvoltage");
    chk_lockout_open: assert property (supply_lockout |=> !boost_power_switch && !led_return_switch)
        else $error("switch closed in lockout");
    chk_hot_open: assert property (over_temp |=> !boost_power_switch && !led_return_switch)
        else $error("switch closed when hot");
endmodule

// >>> tb/test_led_boost_control_sequencer.sv
// Bench joining host and device ends of the sequencer
`timescale 1ns/1ps
module test_led_boost_control_sequencer;
    import lbcs_pkg::*;
    localparam int EN = 50;
    localparam int SD = 200;
    logic ref_clk = 1'b0, rst = 1'b1, run_req = 1'b0, pwm_mode = 1'b0, fb_below_ref = 1'b0;
    logic ilim_quarter_hit = 1'b0, ilim_half_hit = 1'b0, ilim_full_hit = 1'b0;
    logic ovp_active = 1'b0, supply_lockout = 1'b0, over_temp = 1'b0;
    logic [23:0] pwm_period = 24'h64, pwm_high_width = 24'h1e;
    logic boost_power_switch, led_return_switch, enabled, softstart_done, pc, pb, he;
    lbcs_limit_t peak_current_limit;
    int n_errors = 0, cmp_count = 0, k, n, w;
    lbcs_link_if link();
    lbcs_device #(.SHUTDOWN_CYCLES(SD), .ENABLE_CYCLES(EN)) u_lbcs_device (.ref_clk, .rst, .link(link),
        .fb_below_ref, .ilim_quarter_hit, .ilim_half_hit, .ilim_full_hit, .ovp_active, .supply_lockout,
        .over_temp, .boost_power_switch, .led_return_switch, .enabled, .softstart_done, .peak_current_limit);
    lbcs_host #(.SHUTDOWN_CYCLES(SD), .ENABLE_CYCLES(EN)) u_lbcs_host (.ref_clk, .rst, .link(link),
        .run_req, .pwm_mode, .softstart_done, .pwm_period, .pwm_high_width, .host_enabled(he));
    lbcs_chk u_lbcs_chk (.ref_clk, .rst, .ctrl_in(link.ctrl_in), .ilim_quarter_hit, .ilim_half_hit,
        .ilim_full_hit, .ovp_active, .supply_lockout, .over_temp, .boost_power_switch,
        .led_return_switch, .enabled, .softstart_done, .peak_current_limit);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    task automatic t_enable;
        @(posedge ref_clk);
        run_req <= 1'b1;
        for (k = 0; k < 200 && link.ctrl_in !== 1'b1; k++) tick(1);
        for (k = 0; k < 200 && enabled !== 1'b1; k++) tick(1);
        chk(k >= EN - 1 && k < EN + 4, 1);
        chk(he, 1);
        chk(peak_current_limit, LBCS_LIM_QUARTER);
        $display("enable test done");
    endtask
    task automatic t_softstart;
        @(posedge ref_clk);
        {ilim_quarter_hit, ilim_half_hit, ilim_full_hit, fb_below_ref} <= 4'hf;
        n = 0;
        for (k = 0; k < 30000 && n < 512; k++) begin
            tick(1);
            if (boost_power_switch === 1'b1) begin
                n++;
                if (n inside {1, 256, 257, 512}) chk(peak_current_limit, n < 257 ? LBCS_LIM_QUARTER : LBCS_LIM_HALF);
            end
        end
        tick(2);
        chk({softstart_done, peak_current_limit}, {1'b1, LBCS_LIM_FULL});
        $display("soft-start test done");
    endtask
    task automatic t_switch;
        @(posedge ref_clk);
        {ilim_quarter_hit, ilim_half_hit, ilim_full_hit} <= 3'h0;
        for (k = 0; k < 50 && boost_power_switch !== 1'b1; k++) tick(1);
        chk(boost_power_switch, 1);
        @(posedge ref_clk);
        ilim_full_hit <= 1'b1;
        tick(2);
        chk(boost_power_switch, 0);
        @(posedge ref_clk);
        ilim_full_hit <= 1'b0;
        for (k = 0; k < 100 && boost_power_switch !== 1'b1; k++) tick(1);
        chk(k >= MIN_OFF_CYC - 2 && k < 40, 1);
        for (k = 0; k < 400 && boost_power_switch === 1'b1; k++) tick(1);
        chk(k >= MAX_ON_CYC - 2 && k <= MAX_ON_CYC, 1);
        @(posedge ref_clk);
        ovp_active <= 1'b1;
        tick(40);
        chk(boost_power_switch, 0);
        @(posedge ref_clk);
        ovp_active <= 1'b0;
        tick(30);
        chk(boost_power_switch, 1);
        $display("switching test done");
    endtask
    task automatic t_pwm;
        @(posedge ref_clk);
        {pwm_mode, ilim_full_hit} <= 2'h3;
        n = 0;
        w = 0;
        for (k = 0; k < 400; k++) begin
            pc = link.ctrl_in;
            pb = boost_power_switch;
            tick(1);
            chk(led_return_switch, pc);
            if (link.ctrl_in === 1'b1 && pc !== 1'b1) begin
                if (w != 0) chk(n + 1, 16'h64);
                w = 1;
            end
            n = (link.ctrl_in === 1'b1 && pc !== 1'b1) ? 0 : n + 1;
            if (w != 0 && link.ctrl_in === 1'b0 && pc === 1'b1) chk(n, 16'h1e);
            if (boost_power_switch === 1'b1 && pb !== 1'b1) chk(n >= BLANK_CYC - 1, 1);
        end
        $display("pwm test done");
    endtask
    task automatic t_off;
        @(posedge ref_clk);
        {run_req, pwm_mode, ilim_full_hit} <= 3'h0;
        k = 0;
        for (n = 0; n < 600 && enabled === 1'b1; n++) begin
            tick(1);
            k = link.ctrl_in === 1'b1 ? 0 : k + 1;
        end
        chk({k >= SD - 1 && k <= SD + 2, led_return_switch}, 2'h2);
        @(posedge ref_clk);
        run_req <= 1'b1;
        for (k = 0; k < 300 && enabled !== 1'b1; k++) tick(1);
        tick(1);
        chk({led_return_switch, peak_current_limit}, {1'b1, LBCS_LIM_QUARTER});
        @(posedge ref_clk);
        supply_lockout <= 1'b1;
        tick(2);
        chk({enabled, boost_power_switch, led_return_switch}, 0);
        @(posedge ref_clk);
        supply_lockout <= 1'b0;
        for (k = 0; k < 300 && enabled !== 1'b1; k++) tick(1);
        @(posedge ref_clk);
        over_temp <= 1'b1;
        tick(2);
        chk({enabled, boost_power_switch, led_return_switch}, 0);
        $display("shutdown and fault test done");
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(60000 * 20);
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_enable;
        t_softstart;
        t_switch;
        t_pwm;
        t_off;
        report_and_stop;
    end
endmodule
